// *** logic/tcr_params.svh ***
// constants of the time clock control register bank
// assumes a 50 MHz core clock and 16-bit management registers
`ifndef TCR_PARAMS_SVH
`define TCR_PARAMS_SVH

// register page and offsets
`define TCR_PAGE_TIME      3'h4
`define TCR_OFS_CONTROL    5'h14
`define TCR_OFS_DATA_PORT  5'h15
`define TCR_OFS_STATUS     5'h16

// control register fields
`define TCR_CTL_SAMPLE     5
`define TCR_CTL_LOAD       4
`define TCR_CTL_STEP       3
`define TCR_CTL_RUN_ON     2
`define TCR_CTL_RUN_OFF    1
`define TCR_CTL_LOGIC_RST  0

// status register fields
`define TCR_STS_TX_PEND    11
`define TCR_STS_RX_PEND    10
`define TCR_STS_TRIGGER_FIRED_FLAG  9
`define TCR_STS_EVT_PEND   8
`define TCR_STS_IE_MSB     3
`define TCR_STS_IE_LSB     0

// reset values
`define TCR_RST_IRQ_EN     4'h0
`define TCR_RST_WORD       16'h0000

// time keeping
`define TCR_CLK_PERIOD_NS  20
`define TCR_NS_PER_TICK    (1000 / (1000 / `TCR_CLK_PERIOD_NS))
`define TCR_NS_PER_SEC     32'h3b9aca00
`define TCR_TIME_WORDS     4

`endif

// *** logic/tcr_pkg.sv ***
// types shared by the time clock control register bank
// assumes tcr_params.svh is on the include path
package tcr_pkg;
  typedef logic [15:0] tcr_word_t;
  typedef logic [1:0]  tcr_word_idx_t;
  typedef logic [2:0]  tcr_fill_t;

  typedef struct packed {
    logic [31:0] sec;
    logic [31:0] ns;
  } tcr_time_s;

  // what a data port read returns
  typedef enum {
    TCR_PORT_IDLE,
    TCR_PORT_SAMPLED
  } tcr_port_mode_e;
endpackage : tcr_pkg

// *** logic/tcr_clk_if.sv ***
// command and time signals between register bank and time counter
// assumes both ends share one clock
`timescale 1ns/100ps
`default_nettype none
interface tcr_clk_if;
  import tcr_pkg::*;
  logic      load;
  logic      step;
  logic      run;
  logic      hold_rst;
  tcr_time_s staged;
  tcr_time_s now;

  modport ctl (output load, output step, output run, output hold_rst,
               output staged, input now);
  modport cnt (input load, input step, input run, input hold_rst,
               input staged, output now);
endinterface : tcr_clk_if
`default_nettype wire

// *** logic/tcr_time_counter.sv ***
// running seconds and nanoseconds counter of the time clock
// assumes commands are one-cycle pulses from the register bank
`timescale 1ns/100ps
`default_nettype none
`include "tcr_params.svh"
module tcr_time_counter (
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  tcr_clk_if.cnt    clk_if
);
  import tcr_pkg::*;

  localparam logic [31:0] NS_TICK = 32'(`TCR_NS_PER_TICK);

  // adds nanosecond and second amounts and carries at most one second
  function automatic tcr_time_s add_ns(input tcr_time_s t,
                                       input logic [31:0] dns,
                                       input logic [31:0] dsec);
    logic [32:0] sum;
    tcr_time_s   r;
    sum   = {1'b0, t.ns} + {1'b0, dns};
    r.sec = t.sec + dsec;
    if (sum >= {1'b0, `TCR_NS_PER_SEC}) begin
      sum   = sum - {1'b0, `TCR_NS_PER_SEC};
      r.sec = r.sec + 32'h00000001;
    end
    r.ns = sum[31:0];
    return r;
  endfunction : add_ns

  tcr_time_s now_ff;
  tcr_time_s nxt_now;

  always_comb begin
    nxt_now = now_ff;
    if (clk_if.load) begin
      nxt_now = clk_if.staged; // R1
    end else if (clk_if.step) begin
      nxt_now = add_ns(now_ff, clk_if.staged.ns, clk_if.staged.sec); // R2
    end else if (clk_if.run) begin
      nxt_now = add_ns(now_ff, NS_TICK, 32'h00000000);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i || clk_if.hold_rst) begin
      now_ff <= '0; // R6
    end else begin
      now_ff <= nxt_now;
    end
  end

  assign clk_if.now = now_ff;
endmodule : tcr_time_counter
`default_nettype wire

// *** logic/tcr_regs.sv ***
// Functional notes
// (R1) load command copies staged data port words into the time clock
// (R2) step command adds staged data port words to the time clock
// (R3) load, step and disable bits self-clear and read as zero
// (R4) writing one to enable starts the clock; read shows enabled state
// (R5) writing one to disable stops the clock; zero does nothing
// (R6) clock reset bit resets clock, logic and these registers
// (R7) clock reset bit is held until host writes it to zero
// (R8) data port reads give successive 16-bit time words
// (R9) reads past the last available word return zero
// (R10) data port writes store successive 16-bit time words
// (R11) transmit stamp flag follows pending transmit stamps
// (R12) receive stamp flag follows pending receive stamps
// (R13) trigger done set on notified trigger, cleared by status read
// (R14) event stamp flag follows pending event stamps
// (R15) four status low bits enable each interrupt source
// (R16) reserved status bits ignore writes and read zero
// (R17) sample command captures running time for data port reads
// (R18) host selects page four before touching these registers
// (R19) each new command restarts the data port word sequence
// (R20) interrupt output is any flag anded with its enable
//
// control, data port and status registers of the time clock
// assumes the management front end gives one-cycle read and write
// strobes with a register address and the current page select
`timescale 1ns/100ps
`default_nettype none
`include "tcr_params.svh"
module tcr_regs (
  input  wire logic              CLK_I,
  input  wire logic              RST_B_I,
  input  wire logic [2:0]        PAGE_SEL_I,
  input  wire logic [4:0]        REG_ADDR_I,
  input  wire logic              REG_WR_I,
  input  wire logic              REG_RD_I,
  input  wire tcr_pkg::tcr_word_t REG_WDATA_I,
  output var  tcr_pkg::tcr_word_t REG_RDATA_O,
  input  wire logic              TX_STAMP_PEND_I,
  input  wire logic              RX_STAMP_PEND_I,
  input  wire logic              EVT_STAMP_PEND_I,
  input  wire logic              TRIG_FIRE_I,
  input  wire logic              TRIG_NOTIFY_I,
  output logic                   IRQ_O,
  output logic                   CLOCK_RUNNING_O,
  output logic                   CLOCK_LOGIC_RESET_O,
  output logic [31:0]            TIME_SEC_O,
  output logic [31:0]            TIME_NS_O
);
  import tcr_pkg::*;

  // ==========================================================
  // access decode
  // ==========================================================
  logic page_ok;
  logic wr_ctl;
  logic wr_data;
  logic wr_sts;
  logic rd_data;
  logic rd_sts;

  // the device answers only on its own page
  assign page_ok = (PAGE_SEL_I == `TCR_PAGE_TIME); // R18

  always_comb begin
    wr_ctl  = 1'b0;
    wr_data = 1'b0;
    wr_sts  = 1'b0;
    rd_data = 1'b0;
    rd_sts  = 1'b0;
    if (page_ok && REG_ADDR_I == `TCR_OFS_CONTROL) begin
      wr_ctl = REG_WR_I;
    end else if (page_ok && REG_ADDR_I == `TCR_OFS_DATA_PORT) begin
      wr_data = REG_WR_I;
      rd_data = REG_RD_I;
    end else if (page_ok && REG_ADDR_I == `TCR_OFS_STATUS) begin
      wr_sts = REG_WR_I;
      rd_sts = REG_RD_I;
    end
  end

  // ==========================================================
  // control register
  // ==========================================================
  logic logic_rst_ff;
  logic run_ff;
  logic load_ff;
  logic step_ff;
  logic cmd_sample;
  logic cmd_load;
  logic cmd_step;
  logic cmd_any;

  // commands are ignored while the clock logic is held in reset
  assign cmd_sample = wr_ctl && !logic_rst_ff
                      && REG_WDATA_I[`TCR_CTL_SAMPLE];
  assign cmd_load   = wr_ctl && !logic_rst_ff
                      && REG_WDATA_I[`TCR_CTL_LOAD];
  assign cmd_step   = wr_ctl && !logic_rst_ff
                      && REG_WDATA_I[`TCR_CTL_STEP];
  assign cmd_any    = cmd_sample || cmd_load || cmd_step;

  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      logic_rst_ff <= 1'b0;
    end else if (wr_ctl) begin
      // level bit, never cleared by hardware
      logic_rst_ff <= REG_WDATA_I[`TCR_CTL_LOGIC_RST]; // R7
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_B_I || logic_rst_ff) begin
      run_ff <= 1'b0; // R6
    end else if (wr_ctl && REG_WDATA_I[`TCR_CTL_RUN_OFF]) begin
      // stop wins when both bits are written as one
      run_ff <= 1'b0; // R5
    end else if (wr_ctl && REG_WDATA_I[`TCR_CTL_RUN_ON]) begin
      run_ff <= 1'b1; // R4
    end
  end

  // one-cycle command pulses toward the counter
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      load_ff <= 1'b0;
      step_ff <= 1'b0;
    end else begin
      load_ff <= cmd_load; // R1 R3
      step_ff <= cmd_step; // R2 R3
    end
  end

  // ==========================================================
  // data port: staged writes and sampled reads
  // ==========================================================
  tcr_time_s      staged_ff;
  tcr_time_s      sample_ff;
  tcr_fill_t      wr_idx_ff;
  tcr_fill_t      rd_idx_ff;
  tcr_port_mode_e mode_ff;
  tcr_clk_if      clk_if ();

  // word order: ns low, ns high, sec low, sec high
  function automatic tcr_word_t pick_word(input tcr_time_s t,
                                          input tcr_fill_t idx);
    tcr_word_t w;
    w = `TCR_RST_WORD;
    case (idx)
      3'h0: w = t.ns[15:0];
      3'h1: w = t.ns[31:16];
      3'h2: w = t.sec[15:0];
      3'h3: w = t.sec[31:16];
      default: w = `TCR_RST_WORD; // R9
    endcase
    return w;
  endfunction : pick_word

  always_ff @(posedge CLK_I) begin
    if (!RST_B_I || logic_rst_ff) begin
      staged_ff <= '0; // R6
      wr_idx_ff <= 3'h0;
    end else if (cmd_any) begin
      wr_idx_ff <= 3'h0; // R19
    end else if (wr_data && wr_idx_ff < 3'(`TCR_TIME_WORDS)) begin
      case (wr_idx_ff)
        3'h0: staged_ff.ns[15:0]   <= REG_WDATA_I; // R10
        3'h1: staged_ff.ns[31:16]  <= REG_WDATA_I; // R10
        3'h2: staged_ff.sec[15:0]  <= REG_WDATA_I; // R10
        default: staged_ff.sec[31:16] <= REG_WDATA_I; // R10
      endcase
      wr_idx_ff <= wr_idx_ff + 3'h1;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_B_I || logic_rst_ff) begin
      sample_ff <= '0; // R6
      rd_idx_ff <= 3'h0;
      mode_ff   <= TCR_PORT_IDLE;
    end else if (cmd_sample) begin
      sample_ff <= clk_if.now; // R17
      rd_idx_ff <= 3'h0; // R19
      mode_ff   <= TCR_PORT_SAMPLED;
    end else if (cmd_any) begin
      rd_idx_ff <= 3'h0; // R19
      mode_ff   <= TCR_PORT_IDLE;
    end else if (rd_data && rd_idx_ff < 3'(`TCR_TIME_WORDS)) begin
      rd_idx_ff <= rd_idx_ff + 3'h1; // R8
    end
  end

  assign clk_if.load     = load_ff;
  assign clk_if.step     = step_ff;
  assign clk_if.run      = run_ff;
  assign clk_if.hold_rst = logic_rst_ff;
  assign clk_if.staged   = staged_ff;

  tcr_time_counter u_counter (
    .clk_i   (CLK_I),
    .rst_b_i (RST_B_I),
    .clk_if  (clk_if)
  );

  // ==========================================================
  // status flags and interrupt enables
  // ==========================================================
  logic       tx_pend_ff;
  logic       rx_pend_ff;
  logic       evt_pend_ff;
  logic       trigger_fired_flag_ff;
  logic [3:0] irq_en_ff;

  // pending flags mirror the stamp queues, which drain on stamp reads
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I || logic_rst_ff) begin
      tx_pend_ff  <= 1'b0;
      rx_pend_ff  <= 1'b0;
      evt_pend_ff <= 1'b0;
    end else begin
      tx_pend_ff  <= TX_STAMP_PEND_I; // R11
      rx_pend_ff  <= RX_STAMP_PEND_I; // R12
      evt_pend_ff <= EVT_STAMP_PEND_I; // R14
    end
  end

  // a firing in the same cycle as a status read is kept
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I || logic_rst_ff) begin
      trigger_fired_flag_ff <= 1'b0;
    end else if (TRIG_FIRE_I && TRIG_NOTIFY_I) begin
      trigger_fired_flag_ff <= 1'b1; // R13
    end else if (rd_sts) begin
      trigger_fired_flag_ff <= 1'b0; // R13
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_B_I || logic_rst_ff) begin
      irq_en_ff <= `TCR_RST_IRQ_EN;
    end else if (wr_sts) begin
      // upper bits of the write are dropped
      irq_en_ff <= REG_WDATA_I[`TCR_STS_IE_MSB:`TCR_STS_IE_LSB]; // R15 R16
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      IRQ_O <= 1'b0;
    end else begin
      IRQ_O <= (tx_pend_ff   && irq_en_ff[3])
            || (rx_pend_ff   && irq_en_ff[2])
            || (trigger_fired_flag_ff && irq_en_ff[1])
            || (evt_pend_ff  && irq_en_ff[0]); // R20
    end
  end

  // ==========================================================
  // read data and mirrored state
  // ==========================================================
  tcr_word_t nxt_rdata;

  always_comb begin
    nxt_rdata = `TCR_RST_WORD;
    if (page_ok && REG_ADDR_I == `TCR_OFS_CONTROL) begin
      // command bits always read zero
      nxt_rdata[`TCR_CTL_RUN_ON]    = run_ff; // R3 R4
      nxt_rdata[`TCR_CTL_LOGIC_RST] = logic_rst_ff; // R7
    end else if (page_ok && REG_ADDR_I == `TCR_OFS_DATA_PORT) begin
      if (mode_ff == TCR_PORT_SAMPLED) begin
        nxt_rdata = pick_word(sample_ff, rd_idx_ff); // R8 R9
      end
    end else if (page_ok && REG_ADDR_I == `TCR_OFS_STATUS) begin
      nxt_rdata[`TCR_STS_TX_PEND]   = tx_pend_ff;
      nxt_rdata[`TCR_STS_RX_PEND]   = rx_pend_ff;
      nxt_rdata[`TCR_STS_TRIGGER_FIRED_FLAG] = trigger_fired_flag_ff;
      nxt_rdata[`TCR_STS_EVT_PEND]  = evt_pend_ff;
      nxt_rdata[`TCR_STS_IE_MSB:`TCR_STS_IE_LSB] = irq_en_ff; // R16
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      REG_RDATA_O <= `TCR_RST_WORD;
    end else if (REG_RD_I) begin
      REG_RDATA_O <= nxt_rdata;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      CLOCK_RUNNING_O     <= 1'b0;
      CLOCK_LOGIC_RESET_O <= 1'b0;
      TIME_SEC_O          <= 32'h00000000;
      TIME_NS_O           <= 32'h00000000;
    end else begin
      CLOCK_RUNNING_O     <= run_ff;
      CLOCK_LOGIC_RESET_O <= logic_rst_ff; // R6
      TIME_SEC_O          <= clk_if.now.sec;
      TIME_NS_O           <= clk_if.now.ns;
    end
  end
endmodule : tcr_regs
`default_nettype wire

// *** bench/tcr_regs_checker.sv ***
// port checks for the time clock control register bank
// assumes it is bound onto tcr_regs and sees only that module's ports
`timescale 1ns/100ps
`default_nettype none
`include "tcr_params.svh"
module tcr_regs_checker (
  input wire logic               CLK_I,
  input wire logic               RST_B_I,
  input wire logic [2:0]         PAGE_SEL_I,
  input wire logic [4:0]         REG_ADDR_I,
  input wire logic               REG_WR_I,
  input wire logic               REG_RD_I,
  input wire tcr_pkg::tcr_word_t REG_WDATA_I,
  input wire tcr_pkg::tcr_word_t REG_RDATA_O,
  input wire logic               TX_STAMP_PEND_I,
  input wire logic               RX_STAMP_PEND_I,
  input wire logic               EVT_STAMP_PEND_I,
  input wire logic               IRQ_O,
  input wire logic               CLOCK_RUNNING_O,
  input wire logic               CLOCK_LOGIC_RESET_O,
  input wire logic [31:0]        TIME_SEC_O,
  input wire logic [31:0]        TIME_NS_O
);
  import tcr_pkg::*;
  // ==========================================================
  // decoded host accesses
  wire logic       on_pg  = (PAGE_SEL_I == `TCR_PAGE_TIME);
  wire logic       wr_ctl = REG_WR_I && on_pg &&
                            (REG_ADDR_I == `TCR_OFS_CONTROL);
  wire logic       rd_ctl = REG_RD_I && on_pg &&
                            (REG_ADDR_I == `TCR_OFS_CONTROL);
  wire logic       rd_sts = REG_RD_I && on_pg &&
                            (REG_ADDR_I == `TCR_OFS_STATUS);
  wire logic [2:0] pend   = {TX_STAMP_PEND_I, RX_STAMP_PEND_I,
                             EVT_STAMP_PEND_I};
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I);
  // ==========================================================
  // properties
  property p_ctl_read;
    rd_ctl |=> REG_RDATA_O[15:3] == 13'h0000 && !REG_RDATA_O[1];
  endproperty
  property p_sts_rsvd;
    rd_sts |=> REG_RDATA_O[15:12] == 4'h0 && REG_RDATA_O[7:4] == 4'h0;
  endproperty
  property p_refused;
    REG_RD_I && !on_pg |=> REG_RDATA_O == 16'h0000;
  endproperty
  property p_run_on;
    wr_ctl && REG_WDATA_I[2:0] == 3'h4 && !CLOCK_LOGIC_RESET_O
      |-> ##[1:2] CLOCK_RUNNING_O;
  endproperty
  property p_run_off;
    wr_ctl && REG_WDATA_I[1] |-> ##[1:2] !CLOCK_RUNNING_O;
  endproperty
  // the quiet cycle before keeps an earlier disable out of the picture;
  // the mirrored reset lags, so a fresh clock logic reset is excluded
  property p_zero_keep;
    wr_ctl && REG_WDATA_I[2:0] == 3'h0 && CLOCK_RUNNING_O &&
      !CLOCK_LOGIC_RESET_O && !$past(REG_WR_I)
      |=> CLOCK_RUNNING_O [*2];
  endproperty
  // the mirror drops two cycles after the releasing write
  property p_hold_rst;
    CLOCK_LOGIC_RESET_O && !wr_ctl && !$past(wr_ctl)
      |=> CLOCK_LOGIC_RESET_O;
  endproperty
  property p_rst_clears;
    CLOCK_LOGIC_RESET_O [*4] |-> !CLOCK_RUNNING_O && !IRQ_O &&
      TIME_NS_O == 32'h0 && TIME_SEC_O == 32'h0;
  endproperty
  property p_pend;
    rd_sts && $past(RST_B_I) && !CLOCK_LOGIC_RESET_O &&
      !$past(CLOCK_LOGIC_RESET_O) && $stable(pend) &&
      pend == $past(pend, 2)
      |=> {REG_RDATA_O[11:10], REG_RDATA_O[8]} == $past(pend);
  endproperty
  a_ctl_read: assert property (p_ctl_read)
    else $error("control read shows a command bit");
  a_sts_rsvd: assert property (p_sts_rsvd)
    else $error("reserved status bits not zero");
  a_refused: assert property (p_refused)
    else $error("read off the time page not zero");
  a_run_on: assert property (p_run_on)
    else $error("clock did not start");
  a_run_off: assert property (p_run_off)
    else $error("clock did not stop");
  a_zero_keep: assert property (p_zero_keep)
    else $error("zero write changed run state");
  a_hold_rst: assert property (p_hold_rst)
    else $error("clock logic reset dropped by itself");
  a_rst_clears: assert property (p_rst_clears)
    else $error("clock logic reset left state behind");
  a_pend: assert property (p_pend)
    else $error("stamp flags differ from pending inputs");
  c_load: cover property (wr_ctl && REG_WDATA_I[4]);
  c_sample: cover property (wr_ctl && REG_WDATA_I[5]);
  c_irq: cover property ($rose(IRQ_O));
endmodule : tcr_regs_checker

bind tcr_regs tcr_regs_checker tcr_regs_checker_i (
  .CLK_I(CLK_I), .RST_B_I(RST_B_I), .PAGE_SEL_I(PAGE_SEL_I),
  .REG_ADDR_I(REG_ADDR_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
  .REG_WDATA_I(REG_WDATA_I), .REG_RDATA_O(REG_RDATA_O),
  .TX_STAMP_PEND_I(TX_STAMP_PEND_I), .RX_STAMP_PEND_I(RX_STAMP_PEND_I),
  .EVT_STAMP_PEND_I(EVT_STAMP_PEND_I), .IRQ_O(IRQ_O),
  .CLOCK_RUNNING_O(CLOCK_RUNNING_O),
  .CLOCK_LOGIC_RESET_O(CLOCK_LOGIC_RESET_O),
  .TIME_SEC_O(TIME_SEC_O), .TIME_NS_O(TIME_NS_O));
`default_nettype wire

// *** bench/tcr_host_model.sv ***
// host side of the management register path
// assumes one-cycle strobes taken on the rising clock edge
`timescale 1ns/100ps
`default_nettype none
module tcr_host_model (
  input  wire logic               clk_i,
  input  wire tcr_pkg::tcr_word_t rdata_i,
  output var  logic [2:0]         page_o,
  output var  logic [4:0]         addr_o,
  output var  logic               wr_o,
  output var  logic               rd_o,
  output var  tcr_pkg::tcr_word_t wdata_o
);
  import tcr_pkg::*;
  logic [2:0] pg = 3'h4;
  initial begin
    page_o  = 3'h0;
    addr_o  = 5'h00;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
    wdata_o = 16'h0000;
  end
  // ==========================================================
  // bus cycles
  task automatic wr(input logic [4:0] a, input tcr_word_t d);
    @(posedge clk_i);
    page_o  <= pg;
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge clk_i);
    wr_o    <= 1'b0;
    // idle data never repeats the last word
    wdata_o <= ~d;
  endtask : wr
  task automatic rd(input logic [4:0] a, output tcr_word_t d);
    @(posedge clk_i);
    page_o <= pg;
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge clk_i);
    rd_o   <= 1'b0;
    @(posedge clk_i);
    #1;
    d = rdata_i;
  endtask : rd
endmodule : tcr_host_model
`default_nettype wire

// *** bench/test_precision_time_clock_ctrl_regs.sv ***
// self-checking bench for the time clock control register bank
// assumes tcr_regs, its checker and the host model are compiled first
`timescale 1ns/100ps
`default_nettype none
`include "tcr_params.svh"
module test_precision_time_clock_ctrl_regs;
  import tcr_pkg::*;
  logic        clk, rst_b, tx, rx, evt, fire, notify;
  logic        wr, rd, irq, running, lrst;
  logic [2:0]  page;
  logic [4:0]  addr;
  tcr_word_t   wdata, rdata;
  logic [31:0] sec, ns;
  int          fail_count = 0;
  int          samples_checked = 0;
  tcr_regs tcr_regs_i (.CLK_I(clk), .RST_B_I(rst_b), .PAGE_SEL_I(page),
    .REG_ADDR_I(addr), .REG_WR_I(wr), .REG_RD_I(rd), .REG_WDATA_I(wdata),
    .REG_RDATA_O(rdata), .TX_STAMP_PEND_I(tx), .RX_STAMP_PEND_I(rx),
    .EVT_STAMP_PEND_I(evt), .TRIG_FIRE_I(fire), .TRIG_NOTIFY_I(notify),
    .IRQ_O(irq), .CLOCK_RUNNING_O(running), .CLOCK_LOGIC_RESET_O(lrst),
    .TIME_SEC_O(sec), .TIME_NS_O(ns));
  tcr_host_model tcr_host_model_i (.clk_i(clk), .rdata_i(rdata),
    .page_o(page), .addr_o(addr), .wr_o(wr), .rd_o(rd), .wdata_o(wdata));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ==========================================================
  // helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task automatic put_time(input logic [63:0] t);
    for (int i = 0; i < 4; i++)
      tcr_host_model_i.wr(`TCR_OFS_DATA_PORT, t[16*i +: 16]);
  endtask : put_time
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle
  // ==========================================================
  // scenarios
  task automatic t_load_step;
    tcr_word_t v;
    logic [15:0] exp [5] = '{16'h0032, 16'h0000, 16'h00a2, 16'h0000,
                             16'h0000};
    put_time(64'h000000a0_3b9ac9ce);
    tcr_host_model_i.wr(`TCR_OFS_CONTROL, 16'h0010);
    settle(4);
    chk(ns, 32'h3b9ac9ce);
    chk(sec, 32'h000000a0);
    // step crosses a second boundary to exercise the carry
    put_time(64'h00000001_00000064);
    tcr_host_model_i.wr(`TCR_OFS_CONTROL, 16'h0008);
    settle(4);
    chk(ns, 32'h00000032);
    chk(sec, 32'h000000a2);
    tcr_host_model_i.rd(`TCR_OFS_CONTROL, v);
    chk(v, 16'h0000);
    tcr_host_model_i.wr(`TCR_OFS_CONTROL, 16'h0020);
    for (int i = 0; i < 5; i++) begin
      tcr_host_model_i.rd(`TCR_OFS_DATA_PORT, v);
      chk(v, exp[i]);
    end
  endtask : t_load_step
  task automatic t_run;
    tcr_word_t   v;
    logic [31:0] t0;
    tcr_host_model_i.wr(`TCR_OFS_CONTROL, 16'h0004);
    settle(1);
    chk(running, 1'b1);
    t0 = ns;
    settle(10);
    chk(ns - t0, 32'd200);
    tcr_host_model_i.wr(`TCR_OFS_CONTROL, 16'h0000);
    settle(1);
    chk(running, 1'b1);
    tcr_host_model_i.rd(`TCR_OFS_CONTROL, v);
    chk(v, 16'h0004);
    tcr_host_model_i.wr(`TCR_OFS_CONTROL, 16'h0006);
    settle(1);
    chk(running, 1'b0);
    t0 = ns;
    settle(5);
    chk(ns, t0);
  endtask : t_run
  task automatic t_rst;
    tcr_word_t v;
    tcr_host_model_i.wr(`TCR_OFS_STATUS, 16'h000f);
    tcr_host_model_i.wr(`TCR_OFS_CONTROL, 16'h0004);
    // a pending stamp makes the interrupt clear a real effect of reset
    @(posedge clk) tx <= 1'b1;
    settle(3);
    chk(irq, 1'b1);
    tcr_host_model_i.wr(`TCR_OFS_CONTROL, 16'h0001);
    settle(6);
    chk({lrst, running, irq}, 3'b100);
    chk(ns | sec, 32'h0);
    // bit0 stays written as one, so the enable beside it is ignored
    tcr_host_model_i.wr(`TCR_OFS_CONTROL, 16'h0005);
    tcr_host_model_i.rd(`TCR_OFS_CONTROL, v);
    chk(v, 16'h0001);
    tcr_host_model_i.rd(`TCR_OFS_STATUS, v);
    chk(v, 16'h0000);
    tcr_host_model_i.wr(`TCR_OFS_CONTROL, 16'h0000);
    settle(1);
    chk(lrst, 1'b0);
    @(posedge clk) tx <= 1'b0;
  endtask : t_rst
  task automatic t_sts;
    tcr_word_t v;
    tcr_host_model_i.wr(`TCR_OFS_STATUS, 16'hffff);
    @(posedge clk) {tx, evt} <= 2'b11;
    settle(3);
    tcr_host_model_i.rd(`TCR_OFS_STATUS, v);
    chk(v, 16'h090f);
    chk(irq, 1'b1);
    @(posedge clk) {tx, rx, evt} <= 3'b010;
    settle(3);
    tcr_host_model_i.rd(`TCR_OFS_STATUS, v);
    chk(v, 16'h040f);
    @(posedge clk) {rx, fire, notify} <= 3'b011;
    @(posedge clk) fire <= 1'b0;
    settle(2);
    tcr_host_model_i.rd(`TCR_OFS_STATUS, v);
    chk(v, 16'h020f);
    // event left pending so the enable clear below really masks it
    @(posedge clk) {fire, notify, evt} <= 3'b101;
    @(posedge clk) fire <= 1'b0;
    settle(2);
    tcr_host_model_i.rd(`TCR_OFS_STATUS, v);
    chk(v, 16'h010f);
    tcr_host_model_i.wr(`TCR_OFS_STATUS, 16'h0000);
    settle(3);
    chk(irq, 1'b0);
    tcr_host_model_i.pg = 3'h2;
    tcr_host_model_i.rd(`TCR_OFS_STATUS, v);
    chk(v, 16'h0000);
    tcr_host_model_i.pg = 3'h4;
    tcr_host_model_i.rd(5'h1f, v);
    chk(v, 16'h0000);
  endtask : t_sts
  // ==========================================================
  // run control
  task automatic close_out;
    $display("checks %0d errors %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  // the scenarios need well under a thousand cycles
  initial begin
    #100000;
    fail_count++;
    close_out;
  end
  initial begin
    {rst_b, tx, rx, evt, fire, notify} = 6'h00;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    t_load_step;
    t_run;
    t_rst;
    t_sts;
    close_out;
  end
endmodule : test_precision_time_clock_ctrl_regs
`default_nettype wire
